// >>> shared/uart_regs_cfg.svh
// Offsets, field positions, codes and sizes of the holding and interrupt registers
`ifndef UART_REGS_CFG_SVH
`define UART_REGS_CFG_SVH

// ********************************
// Register offsets
// ********************************
`define UR_OFF_HOLD     8'h00
`define UR_OFF_ENABLE   8'h01
`define UR_OFF_STATUS   8'h02

// ********************************
// Enable bits and reset values
// ********************************
`define UR_IER_RX_DATA  0
`define UR_IER_TX_EMPTY 1
`define UR_IER_RX_ERR   2
`define UR_IER_MODEM    3
`define UR_IER_XOFF     4
`define UR_IER_RTS      5
`define UR_IER_CTS      6
`define UR_IER_RESET    8'h00
`define UR_BYTE_ZERO    8'h00

// ********************************
// Status codes
// ********************************
`define UR_ISR_NONE     8'hC1
`define UR_ISR_RX_ERR   8'hC6
`define UR_ISR_RX_DATA  8'hC4
`define UR_ISR_TIMEOUT  8'hCC
`define UR_ISR_TX_EMPTY 8'hC2
`define UR_ISR_MODEM    8'hC0
`define UR_ISR_XOFF     8'hD0
`define UR_ISR_FLOW     8'hE0

// ********************************
// FIFO control bits and sizes
// ********************************
`define UR_FCR_MODE     0
`define UR_FCR_RX_FLUSH 1
`define UR_FCR_TX_FLUSH 2
`define UR_FIFO_DEPTH   32
`define UR_DATA_W       8

`endif

// >>> shared/uart_regs_pkg.sv
// Types shared by the holding and interrupt register block
package uart_regs_pkg;
  typedef logic [7:0] byte_type;
  typedef struct packed {
    logic rx_err;
    logic rx_data;
    logic timeout;
    logic tx_empty;
    logic modem;
    logic xoff;
    logic flow;
  } pend_type;
endpackage

// >>> shared/stream_if.sv
// Valid/ready byte stream between the register block and its FIFOs
`timescale 1ns/100ps
interface stream_if #(parameter int W = 8) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> hw/sync_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a flush
`timescale 1ns/100ps
`include "uart_regs_cfg.svh"
module sync_fifo #(
  parameter int W     = `UR_DATA_W,
  parameter int DEPTH = `UR_FIFO_DEPTH
) (
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     flush,
  stream_if.snk                         wr,
  stream_if.src                         rd,
  output      logic [$clog2(DEPTH):0]   count
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
      $error("sync_fifo DEPTH must be a power of two of at least 2");
    end
  endgenerate

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wptr_reg;
  logic [AW:0]  rptr_reg;
  logic         push;
  logic         pop;

  // Full when pointers differ only in the wrap bit
  assign wr.ready = !((wptr_reg[AW] != rptr_reg[AW]) &&
                      (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]));
  assign rd.valid = (wptr_reg != rptr_reg);
  assign rd.data  = mem[rptr_reg[AW-1:0]];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;
  assign count    = wptr_reg - rptr_reg;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wptr_reg[AW-1:0]] <= wr.data;
    end
  end

  // Flush wins over a push or pop in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst || flush) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
    end
  end
endmodule // sync_fifo

// >>> hw/irq_prio.sv
// Fixed-priority encoder from pending sources to the status code
`timescale 1ns/100ps
`include "uart_regs_cfg.svh"
module irq_prio
  import uart_regs_pkg::*;
(
  input  wire pend_type pend,
  output      byte_type code
);
  always_comb begin
    if (pend.rx_err) begin
      code = `UR_ISR_RX_ERR;
    end else if (pend.rx_data) begin
      code = `UR_ISR_RX_DATA;
    end else if (pend.timeout) begin
      code = `UR_ISR_TIMEOUT;
    end else if (pend.tx_empty) begin
      code = `UR_ISR_TX_EMPTY;
    end else if (pend.modem) begin
      code = `UR_ISR_MODEM;
    end else if (pend.xoff) begin
      code = `UR_ISR_XOFF;
    end else if (pend.flow) begin
      code = `UR_ISR_FLOW;
    end else begin
      code = `UR_ISR_NONE;
    end
  end
endmodule // irq_prio

// >>> hw/uart_hold_irq.sv
// Holding, interrupt enable and interrupt status registers of one UART channel
`timescale 1ns/100ps
`include "uart_regs_cfg.svh"
// How it works
// - Holding read returns oldest byte and pops
// - Holding write appends byte to transmit tail
// - Write to full transmit queue is dropped
// - Enable bit 0 gates receive data ready
// - Enable bit 1 gates transmit empty
// - Enable bit 2 gates receive error
// - Enable bit 3 gates modem status change
// - Enable bit 4 gates xoff/special character
// - Enable bit 5 gates RTS/DTR change
// - Enable bit 6 gates CTS/DSR change
// - Status reads C1 when nothing pending
// - Status reports highest priority source only
// - Fixed status code per source, top bits set
// - Divisor latch select steals offsets zero, one
// - Offset two: read status, write FIFO control
module uart_hold_irq
  import uart_regs_pkg::*;
#(
  parameter int FIFO_DEPTH = `UR_FIFO_DEPTH
) (
  input  wire logic     sys_clk,
  input  wire logic     sys_rst,
  input  wire byte_type reg_addr,
  input  wire logic     reg_wr,
  input  wire logic     reg_rd,
  input  wire byte_type reg_wdata,
  output      byte_type reg_rdata,
  input  wire logic     line_control_dlab,
  input  wire logic     rx_in_valid,
  output      logic     rx_in_ready,
  input  wire byte_type rx_in_data,
  output      logic     tx_out_valid,
  input  wire logic     tx_out_ready,
  output      byte_type tx_out_data,
  input  wire logic     rx_error,
  input  wire logic     rx_timeout,
  input  wire logic     modem_change,
  input  wire logic     xoff_detect,
  input  wire logic     rts_change,
  input  wire logic     cts_change,
  output      logic     fifo_mode,
  output      logic     irq
);
  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  generate
    if (FIFO_DEPTH < 2) begin : g_bad
      $error("uart_hold_irq FIFO_DEPTH must be at least 2");
    end
  endgenerate

  // ********************************
  // Queues
  // ********************************
  stream_if #(.W(`UR_DATA_W)) rx_wr ();
  stream_if #(.W(`UR_DATA_W)) rx_rd ();
  stream_if #(.W(`UR_DATA_W)) tx_wr ();
  stream_if #(.W(`UR_DATA_W)) tx_rd ();

  logic [CW-1:0] rx_count;
  logic [CW-1:0] tx_count;
  logic          rx_flush_reg;
  logic          tx_flush_reg;
  logic          sel_hold;
  logic          sel_en;
  logic          sel_stat;
  logic          rx_pop;
  logic          tx_push;

  assign rx_wr.valid  = rx_in_valid;
  assign rx_wr.data   = rx_in_data;
  assign rx_in_ready  = rx_wr.ready;
  assign tx_out_valid = tx_rd.valid;
  assign tx_out_data  = tx_rd.data;
  assign tx_rd.ready  = tx_out_ready;

  sync_fifo #(.W(`UR_DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .flush   (rx_flush_reg),
    .wr      (rx_wr),
    .rd      (rx_rd),
    .count   (rx_count)
  );

  sync_fifo #(.W(`UR_DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .flush   (tx_flush_reg),
    .wr      (tx_wr),
    .rd      (tx_rd),
    .count   (tx_count)
  );

  // ********************************
  // Address decode
  // ********************************
  // Divisor latch owns offsets zero and one while selected
  assign sel_hold = (reg_addr == `UR_OFF_HOLD) && !line_control_dlab;
  assign sel_en   = (reg_addr == `UR_OFF_ENABLE) && !line_control_dlab;
  assign sel_stat = (reg_addr == `UR_OFF_STATUS);

  // Pop only on a holding read; empty reads leave the queue alone
  assign rx_pop      = reg_rd && sel_hold;
  assign rx_rd.ready = rx_pop;
  assign tx_push     = reg_wr && sel_hold;
  assign tx_wr.valid = tx_push;
  assign tx_wr.data  = reg_wdata;
  // Full queue drops the byte since ready is low

  // ********************************
  // Enable and FIFO control
  // ********************************
  byte_type ier_reg;
  logic     fifo_mode_reg;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ier_reg <= `UR_IER_RESET;
    end else if (reg_wr && sel_en) begin
      ier_reg <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fifo_mode_reg <= 1'b0;
    end else if (reg_wr && sel_stat) begin
      fifo_mode_reg <= reg_wdata[`UR_FCR_MODE];
    end
  end

  // Flush bits are self-clearing one-cycle pulses
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rx_flush_reg <= 1'b0;
      tx_flush_reg <= 1'b0;
    end else begin
      rx_flush_reg <= reg_wr && sel_stat && reg_wdata[`UR_FCR_RX_FLUSH];
      tx_flush_reg <= reg_wr && sel_stat && reg_wdata[`UR_FCR_TX_FLUSH];
    end
  end

  assign fifo_mode = fifo_mode_reg;

  // ********************************
  // Interrupt sources
  // ********************************
  // Sources are live levels; a status read clears nothing
  // Timeout shares the data-ready enable, as a receive event
  pend_type pend;
  byte_type isr_code;
  logic     irq_reg;

  always_comb begin
    pend.rx_err   = rx_error && ier_reg[`UR_IER_RX_ERR];
    pend.rx_data  = rx_rd.valid && ier_reg[`UR_IER_RX_DATA];
    pend.timeout  = rx_timeout && ier_reg[`UR_IER_RX_DATA];
    pend.tx_empty = !tx_rd.valid && ier_reg[`UR_IER_TX_EMPTY];
    pend.modem    = modem_change && ier_reg[`UR_IER_MODEM];
    pend.xoff     = xoff_detect && ier_reg[`UR_IER_XOFF];
    pend.flow     = (rts_change && ier_reg[`UR_IER_RTS]) ||
                    (cts_change && ier_reg[`UR_IER_CTS]);
  end

  irq_prio u_prio (
    .pend (pend),
    .code (isr_code)
  );

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (pend != '0);
    end
  end

  assign irq = irq_reg;

  // ********************************
  // Read data
  // ********************************
  // Registered so a read answers one cycle after its strobe
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= `UR_BYTE_ZERO;
    end else if (reg_rd) begin
      if (sel_hold) begin
        reg_rdata <= rx_rd.data;
      end else if (sel_en) begin
        reg_rdata <= ier_reg;
      end else if (sel_stat) begin
        reg_rdata <= isr_code;
      end else begin
        reg_rdata <= `UR_BYTE_ZERO;
      end
    end
  end

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_rhr_data;
    reg_rd && sel_hold |=> reg_rdata == $past(rx_rd.data);
  endproperty
  a_rhr_data: assert property (p_rhr_data) else $error("holding read data wrong");

  property p_rhr_pop;
    rx_pop && rx_rd.valid && !(rx_in_valid && rx_in_ready) && !rx_flush_reg
      |=> rx_count == $past(rx_count) - 1'b1;
  endproperty
  a_rhr_pop: assert property (p_rhr_pop) else $error("holding read did not pop");

  property p_thr_push;
    tx_push && tx_wr.ready && !(tx_out_valid && tx_out_ready) && !tx_flush_reg
      |=> tx_count == $past(tx_count) + 1'b1;
  endproperty
  a_thr_push: assert property (p_thr_push) else $error("holding write lost");

  property p_thr_full;
    tx_push && !tx_wr.ready && !tx_out_ready && !tx_flush_reg
      |=> $stable(tx_count) ##0 !tx_wr.ready;
  endproperty
  a_thr_full: assert property (p_thr_full) else $error("full queue accepted byte");

  property p_ier_write;
    reg_wr && sel_en |=> ier_reg == $past(reg_wdata);
  endproperty
  a_ier_write: assert property (p_ier_write) else $error("enable write wrong");

  property p_dlab;
    line_control_dlab && reg_wr && reg_addr == `UR_OFF_ENABLE |=> $stable(ier_reg);
  endproperty
  a_dlab: assert property (p_dlab) else $error("enable written under divisor select");

  property p_isr_none;
    reg_rd && sel_stat && pend == '0 |=> reg_rdata == `UR_ISR_NONE;
  endproperty
  a_isr_none: assert property (p_isr_none) else $error("idle status not C1");

  property p_isr_top;
    reg_rd && sel_stat && pend.rx_err |=> reg_rdata == `UR_ISR_RX_ERR;
  endproperty
  a_isr_top: assert property (p_isr_top) else $error("receive error not on top");

  property p_isr_tx;
    reg_rd && sel_stat && pend == 7'b0001000 |=> reg_rdata == `UR_ISR_TX_EMPTY;
  endproperty
  a_isr_tx: assert property (p_isr_tx) else $error("transmit empty code wrong");

  property p_irq_off;
    ier_reg == `UR_IER_RESET ##1 ier_reg == `UR_IER_RESET |-> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("request with all masked");

  property p_fcr;
    reg_wr && sel_stat |=> fifo_mode == $past(reg_wdata[`UR_FCR_MODE]);
  endproperty
  a_fcr: assert property (p_fcr) else $error("FIFO mode not written");

  property p_ier_hold;
    !(reg_wr && sel_en) |=> $stable(ier_reg);
  endproperty
  a_ier_hold: assert property (p_ier_hold) else $error("enable changed unwritten");

  property p_irq_on;
    pend != '0 |=> irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("request missing while pending");

  property p_flush;
    rx_flush_reg || tx_flush_reg
      |=> (!$past(rx_flush_reg) || rx_count == '0) && (!$past(tx_flush_reg) || tx_count == '0);
  endproperty
  a_flush: assert property (p_flush) else $error("flush left bytes queued");

  property p_rx_empty_read;
    reg_rd && sel_hold && !rx_rd.valid && !rx_in_valid && !rx_flush_reg
      |=> rx_count == '0;
  endproperty
  a_rx_empty_read: assert property (p_rx_empty_read) else $error("empty read popped");

  property p_isr_data;
    reg_rd && sel_stat && !pend.rx_err && pend.rx_data |=> reg_rdata == `UR_ISR_RX_DATA;
  endproperty
  a_isr_data: assert property (p_isr_data) else $error("data ready code wrong");

  c_rx_read: cover property (reg_rd && sel_hold && rx_rd.valid);
  c_tx_full: cover property (tx_push && !tx_wr.ready);
  c_irq:     cover property (!irq ##1 irq);
  c_prio:    cover property (reg_rd && sel_stat && pend.rx_err && pend.rx_data);
  c_flush:   cover property (tx_flush_reg && tx_rd.valid);
endmodule // uart_hold_irq

// >>> verif/uart_far_end.sv
// Far-side model: receiver feeding bytes in, transmitter draining bytes out
`timescale 1ns/100ps
module uart_far_end
  import uart_regs_pkg::*;
(
  input  wire logic     sys_clk,
  input  wire logic     sys_rst,
  input  wire logic     stall,
  output      logic     rx_in_valid,
  output      byte_type rx_in_data,
  input  wire logic     rx_in_ready,
  input  wire logic     tx_out_valid,
  input  wire byte_type tx_out_data,
  output      logic     tx_out_ready
);
  byte_type got [64];
  int       n_got;

  initial begin
    rx_in_valid = 1'h0;
    rx_in_data  = 8'h00;
  end

  // Stall stands in for a transmitter busy shifting a byte
  assign tx_out_ready = ~stall;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      n_got <= 0;
    end else if (tx_out_valid && tx_out_ready) begin
      got[n_got] <= tx_out_data;
      n_got      <= n_got + 1;
    end
  end

  // Ready is read at the falling edge, where it is settled
  task automatic send(input byte_type b, output logic ok);
    int i;
    @(negedge sys_clk);
    rx_in_valid = 1'h1;
    rx_in_data  = b;
    ok = 1'h0;
    for (i = 0; i < 50 && !ok; i++) begin
      ok = rx_in_ready;
      @(negedge sys_clk);
    end
    rx_in_valid = 1'h0;
    // Idle data flips so a stale byte never looks fresh
    rx_in_data = ~b;
  endtask
endmodule // uart_far_end

// >>> verif/uart_hold_irq_test.sv
// Self-checking bench for the holding and interrupt register block
`timescale 1ns/100ps
`include "uart_regs_cfg.svh"
module uart_hold_irq_test;
  import uart_regs_pkg::*;
  // *****
  // Signals
  // *****
  logic       sys_clk, sys_rst, reg_wr, reg_rd, dlab, stall, ok;
  logic       rx_in_valid, rx_in_ready, tx_out_valid, tx_out_ready, fifo_mode, irq;
  byte_type   reg_addr, reg_wdata, reg_rdata, rx_in_data, tx_out_data, rd_val;
  logic [5:0] src;
  int         n_errors, comparisons, k;
  byte_type   gate_tab [7] = '{`UR_ISR_TIMEOUT, `UR_ISR_TX_EMPTY, `UR_ISR_RX_ERR,
                               `UR_ISR_MODEM, `UR_ISR_XOFF, `UR_ISR_FLOW, `UR_ISR_FLOW};
  byte_type   drop_tab [4] = '{`UR_ISR_XOFF, `UR_ISR_FLOW, `UR_ISR_FLOW, `UR_ISR_NONE};

  uart_hold_irq dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .line_control_dlab(dlab), .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready),
    .rx_in_data(rx_in_data), .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready),
    .tx_out_data(tx_out_data), .rx_error(src[0]), .rx_timeout(src[1]),
    .modem_change(src[2]), .xoff_detect(src[3]), .rts_change(src[4]),
    .cts_change(src[5]), .fifo_mode(fifo_mode), .irq(irq));

  uart_far_end far (.sys_clk(sys_clk), .sys_rst(sys_rst), .stall(stall),
    .rx_in_valid(rx_in_valid), .rx_in_data(rx_in_data), .rx_in_ready(rx_in_ready),
    .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data), .tx_out_ready(tx_out_ready));

  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end
  // *****
  // Tasks
  // *****
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input byte_type a, input byte_type d);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'h1;
    @(negedge sys_clk);
    reg_wr = 1'h0;
  endtask
  task automatic rd(input byte_type a);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd   = 1'h1;
    @(negedge sys_clk);
    reg_rd = 1'h0;
    rd_val = reg_rdata;
  endtask
  task automatic rd_chk(input string name, input byte_type a, input byte_type exp);
    rd(a);
    check(name, rd_val, exp);
  endtask
  // Pending state is combinational and irq is registered; three cycles covers both
  task automatic settle;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // *****
  // Sequence
  // *****
  initial begin
    sys_rst = 1'h1;
    {reg_wr, reg_rd, dlab, stall} = 4'h0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    src = 6'h00;
    n_errors = 0;
    comparisons = 0;
    repeat (20) @(negedge sys_clk);
    sys_rst = 1'h0;
    rd_chk("enable reset", `UR_OFF_ENABLE, `UR_IER_RESET);
    rd_chk("status reset", `UR_OFF_STATUS, `UR_ISR_NONE);
    check("irq reset", {7'h00, irq}, 8'h00);
    wr(`UR_OFF_ENABLE, 8'hFF);
    rd_chk("enable all", `UR_OFF_ENABLE, 8'hFF);
    dlab = 1'h1;
    wr(`UR_OFF_ENABLE, 8'h00);
    wr(`UR_OFF_HOLD, 8'h5A);
    rd_chk("enable dlab", `UR_OFF_ENABLE, `UR_BYTE_ZERO);
    dlab = 1'h0;
    rd_chk("enable kept", `UR_OFF_ENABLE, 8'hFF);
    check("tx dlab", {7'h00, tx_out_valid}, 8'h00);
    rd_chk("unmapped", 8'h03, `UR_BYTE_ZERO);
    wr(`UR_OFF_STATUS, 8'h01);
    check("fifo mode", {7'h00, fifo_mode}, 8'h01);
    // One enable bit at a time, every source active except receive data
    src = 6'h3F;
    for (k = 0; k < 7; k++) begin
      wr(`UR_OFF_ENABLE, byte_type'(8'h01 << k));
      settle;
      rd_chk("gated code", `UR_OFF_STATUS, gate_tab[k]);
      check("irq on", {7'h00, irq}, 8'h01);
    end
    wr(`UR_OFF_ENABLE, 8'h80);
    settle;
    rd_chk("all masked", `UR_OFF_STATUS, `UR_ISR_NONE);
    check("irq off", {7'h00, irq}, 8'h00);
    // Remove the top source step by step
    wr(`UR_OFF_ENABLE, 8'h7F);
    far.send(8'hA5, ok);
    settle;
    rd_chk("prio err", `UR_OFF_STATUS, `UR_ISR_RX_ERR);
    src[0] = 1'h0;
    settle;
    rd_chk("prio data", `UR_OFF_STATUS, `UR_ISR_RX_DATA);
    rd_chk("rx head", `UR_OFF_HOLD, 8'hA5);
    settle;
    rd_chk("prio timeout", `UR_OFF_STATUS, `UR_ISR_TIMEOUT);
    src[1] = 1'h0;
    settle;
    rd_chk("prio tx empty", `UR_OFF_STATUS, `UR_ISR_TX_EMPTY);
    stall = 1'h1;
    wr(`UR_OFF_HOLD, 8'h3C);
    settle;
    rd_chk("prio modem", `UR_OFF_STATUS, `UR_ISR_MODEM);
    for (k = 0; k < 4; k++) begin
      src[k + 2] = 1'h0;
      settle;
      rd_chk("prio low", `UR_OFF_STATUS, drop_tab[k]);
    end
    // Fill the stalled transmit queue past full
    for (k = 1; k < 33; k++) wr(`UR_OFF_HOLD, byte_type'(8'h10 + k));
    stall = 1'h0;
    for (k = 0; k < 300 && far.n_got < 32; k++) @(negedge sys_clk);
    settle;
    check("tx count", byte_type'(far.n_got), 8'h20);
    check("tx first", far.got[0], 8'h3C);
    for (k = 1; k < 32; k++) check("tx order", far.got[k], byte_type'(8'h10 + k));
    // Receive queue order, then an empty read
    for (k = 0; k < 3; k++) far.send(byte_type'(8'hB0 + k), ok);
    check("rx taken", {7'h00, ok}, 8'h01);
    for (k = 0; k < 3; k++) rd_chk("rx order", `UR_OFF_HOLD, byte_type'(8'hB0 + k));
    rd(`UR_OFF_HOLD);
    far.send(8'hC7, ok);
    rd_chk("rx after empty", `UR_OFF_HOLD, 8'hC7);
    // Flush drops a queued byte on each side
    stall = 1'h1;
    wr(`UR_OFF_HOLD, 8'h77);
    far.send(8'h66, ok);
    wr(`UR_OFF_STATUS, 8'h07);
    settle;
    check("tx flushed", {7'h00, tx_out_valid}, 8'h00);
    rd_chk("rx flushed", `UR_OFF_STATUS, `UR_ISR_TX_EMPTY);
    wrap_up;
  end
endmodule // uart_hold_irq_test
